// ### hw/fifo_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_uart_consts.svh"

module fifo_serial_port
    import fifo_uart_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // register port
    input  wire reg_req_type req_i,
    output logic [15:0]      rdata_o,
    output logic             irq_o,
    // serial line and modem control
    input  wire logic        serial_in_i,
    output logic             serial_out_o,
    output logic             request_to_send_line_n_o,
    input  wire logic        clear_to_send_line_n_i,
    // serial clock pin
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_o
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        frame_cfg_type               cfg;
        logic                        te;
        logic                        re;
        logic                        mce;
        logic                        clk_out;
        logic                        clk_ext;
        logic [15:0]                 baud_div;
        logic [15:0]                 baud_cnt;
        logic                        sck_q;
        logic                        sck_last;
        logic [`STATUS_W-1:0]        status;
        logic [`STATUS_W-1:0]        mask;
        logic [15:0]                 rdata;
        logic [DEPTH-1:0][7:0]       txm;
        logic [DEPTH-1:0][7:0]       rxm;
        logic [AW-1:0]               tx_wp;
        logic [AW-1:0]               tx_rp;
        logic [AW-1:0]               rx_wp;
        logic [AW-1:0]               rx_rp;
        logic [AW:0]                 tx_cnt;
        logic [AW:0]                 rx_cnt;
        tx_state_type                txs;
        logic [3:0]                  tx_tick;
        logic [2:0]                  tx_bit;
        logic [7:0]                  tx_sh;
        logic                        tx_par;
        logic                        tx_line;
        rx_state_type                rxs;
        logic [3:0]                  rx_tick;
        logic [2:0]                  rx_bit;
        logic [7:0]                  rx_sh;
        logic                        rx_perr;
        logic                        rxd_q;
    } state_type;

    state_type q;
    state_type d;

    function automatic logic [2:0] last_bit(input frame_cfg_type c);
        return c.char7 ? 3'h6 : 3'h7;
    endfunction

    function automatic logic [7:0] char_mask(input frame_cfg_type c, input logic [7:0] v);
        return c.char7 ? {1'b0, v[6:0]} : v;
    endfunction

    logic                  tick;
    logic                  tx_push;
    logic                  tx_pop;
    logic                  rx_push;
    logic                  rx_pop;
    logic [`STATUS_W-1:0]  set_ev;
    logic [`STATUS_W-1:0]  clr_ev;
    logic [7:0]            tx_word;

    always_comb begin
        d      = q;
        set_ev = '0;
        clr_ev = '0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        tx_word = q.txm[q.tx_rp];

        // 16x tick: baud divider or rising edge of the external pin
        d.sck_last = serial_clock_pin_i;
        if (q.baud_cnt >= q.baud_div) begin
            d.baud_cnt = 16'h0000;
        end else begin
            d.baud_cnt = q.baud_cnt + 16'h0001;
        end
        d.sck_q = (q.baud_cnt < {1'b0, q.baud_div[15:1]});
        tick = q.clk_ext ? (serial_clock_pin_i & ~q.sck_last)
                         : (q.baud_cnt >= q.baud_div);

        // register port; read data stands one cycle after the strobe
        tx_push = req_i.wr && (req_i.addr == `TXDATA_OFS) && (q.tx_cnt != FULL_CNT);
        rx_pop  = req_i.rd && (req_i.addr == `RXDATA_OFS) && (q.rx_cnt != '0);
        d.rdata = 16'h0000;
        if (req_i.rd) begin
            unique case (req_i.addr)
                `MODE_OFS: begin
                    d.rdata[`MODE_CHAR7_BIT]   = q.cfg.char7;
                    d.rdata[`MODE_PAR_EN_BIT]  = q.cfg.par_en;
                    d.rdata[`MODE_PAR_ODD_BIT] = q.cfg.par_odd;
                    d.rdata[`MODE_STOP2_BIT]   = q.cfg.stop2;
                end
                `CTRL_OFS: begin
                    d.rdata[`CTRL_TE_BIT]     = q.te;
                    d.rdata[`CTRL_RE_BIT]     = q.re;
                    d.rdata[`CTRL_MCE_BIT]    = q.mce;
                    d.rdata[`CTRL_CLKOUT_BIT] = q.clk_out;
                    d.rdata[`CTRL_CLKSRC_BIT] = q.clk_ext;
                end
                `BAUD_OFS:   d.rdata = q.baud_div;
                `RXDATA_OFS: d.rdata = {8'h00, q.rxm[q.rx_rp]};
                `COUNT_OFS:  d.rdata = {3'h0, 5'(q.tx_cnt), 3'h0, 5'(q.rx_cnt)};
                `STATUS_OFS: d.rdata = {9'h000, q.status};
                `MASK_OFS:   d.rdata = {9'h000, q.mask};
                default:     d.rdata = 16'h0000;
            endcase
        end
        if (req_i.wr) begin
            unique case (req_i.addr)
                `MODE_OFS: begin
                    d.cfg.char7   = req_i.wdata[`MODE_CHAR7_BIT];
                    d.cfg.par_en  = req_i.wdata[`MODE_PAR_EN_BIT];
                    d.cfg.par_odd = req_i.wdata[`MODE_PAR_ODD_BIT];
                    d.cfg.stop2   = req_i.wdata[`MODE_STOP2_BIT];
                end
                `CTRL_OFS: begin
                    d.te      = req_i.wdata[`CTRL_TE_BIT];
                    d.re      = req_i.wdata[`CTRL_RE_BIT];
                    d.mce     = req_i.wdata[`CTRL_MCE_BIT];
                    d.clk_out = req_i.wdata[`CTRL_CLKOUT_BIT];
                    d.clk_ext = req_i.wdata[`CTRL_CLKSRC_BIT];
                end
                `BAUD_OFS:   d.baud_div = req_i.wdata;
                `STATUS_OFS: clr_ev = req_i.wdata[`STATUS_W-1:0];
                `MASK_OFS:   d.mask = req_i.wdata[`STATUS_W-1:0];
                default: begin
                end
            endcase
        end

        // transmitter
        if (!q.te) begin
            d.txs     = TX_IDLE;
            d.tx_line = 1'b1;
        end else begin
            unique case (q.txs)
                TX_IDLE: begin
                    d.tx_line = 1'b1;
                    // with modem control on, clear-to-send high holds the next frame back; a running one completes
                    if ((q.tx_cnt != '0) && !(q.mce && clear_to_send_line_n_i)) begin
                        tx_pop    = 1'b1;
                        d.tx_sh   = char_mask(q.cfg, tx_word);
                        d.tx_par  = (^char_mask(q.cfg, tx_word)) ^ q.cfg.par_odd;
                        d.txs     = TX_START;
                        d.tx_tick = 4'h0;
                        d.tx_bit  = 3'h0;
                        d.tx_line = 1'b0;
                    end
                end
                default: begin
                    if (tick) begin
                        d.tx_tick = q.tx_tick + 4'h1;
                    end
                    if (tick && (q.tx_tick == `OVERSAMPLE_LAST)) begin
                        unique case (q.txs)
                            TX_START: begin
                                d.txs     = TX_DATA;
                                d.tx_line = q.tx_sh[0];
                            end
                            TX_DATA: begin
                                if (q.tx_bit == last_bit(q.cfg)) begin
                                    d.tx_bit = 3'h0;
                                    if (q.cfg.par_en) begin
                                        d.txs     = TX_PAR;
                                        d.tx_line = q.tx_par;
                                    end else begin
                                        d.txs     = TX_STOP;
                                        d.tx_line = 1'b1;
                                    end
                                end else begin
                                    d.tx_bit  = q.tx_bit + 3'h1;
                                    d.tx_sh   = {1'b0, q.tx_sh[7:1]};
                                    d.tx_line = q.tx_sh[1];
                                end
                            end
                            TX_PAR: begin
                                d.txs     = TX_STOP;
                                d.tx_line = 1'b1;
                            end
                            TX_STOP: begin
                                if (q.cfg.stop2 && (q.tx_bit == 3'h0)) begin
                                    d.tx_bit = 3'h1;
                                end else begin
                                    d.txs = TX_IDLE;
                                    if (q.tx_cnt == '0) begin
                                        set_ev[`ST_TX_EMPTY] = 1'b1;
                                    end
                                end
                            end
                            default: d.txs = TX_IDLE;
                        endcase
                    end
                end
            endcase
        end

        // receiver
        d.rxd_q = serial_in_i;
        if (!q.re) begin
            d.rxs = RX_IDLE;
        end else begin
            unique case (q.rxs)
                RX_IDLE: begin
                    if (q.rxd_q && !serial_in_i) begin
                        d.rxs     = RX_START;
                        d.rx_tick = 4'h0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        d.rx_tick = q.rx_tick + 4'h1;
                        if (q.rx_tick == `MID_BIT_TICK) begin
                            // a start bit gone high by mid-bit was a glitch
                            d.rxs     = serial_in_i ? RX_IDLE : RX_DATA;
                            d.rx_tick = 4'h0;
                            d.rx_bit  = 3'h0;
                            d.rx_sh   = 8'h00;
                            d.rx_perr = 1'b0;
                        end
                    end
                end
                default: begin
                    if (tick) begin
                        d.rx_tick = q.rx_tick + 4'h1;
                    end
                    if (tick && (q.rx_tick == `OVERSAMPLE_LAST)) begin
                        unique case (q.rxs)
                            RX_DATA: begin
                                d.rx_sh[q.rx_bit] = serial_in_i;
                                d.rx_bit = q.rx_bit + 3'h1;
                                if (q.rx_bit == last_bit(q.cfg)) begin
                                    d.rxs = q.cfg.par_en ? RX_PAR : RX_STOP;
                                end
                            end
                            RX_PAR: begin
                                d.rx_perr = serial_in_i ^ (^q.rx_sh) ^ q.cfg.par_odd;
                                d.rxs     = RX_STOP;
                            end
                            RX_STOP: begin
                                // only the first stop bit is looked at
                                d.rxs = RX_IDLE;
                                set_ev[`ST_FRAMING] = !serial_in_i;
                                set_ev[`ST_PARITY]  = q.rx_perr;
                                set_ev[`ST_BREAK]   = !serial_in_i && (q.rx_sh == 8'h00)
                                                      && !q.rx_perr;
                                if ((q.rx_cnt == FULL_CNT) && !rx_pop) begin
                                    set_ev[`ST_OVERRUN] = 1'b1;
                                end else begin
                                    rx_push = 1'b1;
                                end
                            end
                            default: d.rxs = RX_IDLE;
                        endcase
                    end
                end
            endcase
        end

        // fifo storage and fill levels
        if (tx_push) begin
            d.txm[q.tx_wp] = req_i.wdata[7:0];
            d.tx_wp = q.tx_wp + 1'b1;
        end
        if (tx_pop) begin
            d.tx_rp = q.tx_rp + 1'b1;
        end
        if (rx_push) begin
            d.rxm[q.rx_wp] = q.rx_sh;
            d.rx_wp = q.rx_wp + 1'b1;
            set_ev[`ST_RX_READY] = 1'b1;
        end
        if (rx_pop) begin
            d.rx_rp = q.rx_rp + 1'b1;
        end
        d.tx_cnt = q.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
        d.rx_cnt = q.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
        if (rx_push && !rx_pop && (q.rx_cnt == FULL_CNT - 1'b1)) begin
            set_ev[`ST_RX_FULL] = 1'b1;
        end

        // a new event beats a same-cycle write-one clear
        d.status = (q.status & ~clr_ev) | set_ev;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q          <= '0;
            q.tx_line  <= 1'b1;
            q.rxd_q    <= 1'b1;
            q.baud_div <= `BAUD_DIV_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign rdata_o      = q.rdata;
    assign irq_o        = |(q.status & q.mask);
    assign serial_out_o = q.tx_line;
    // low means room to receive; high when disabled, or when nearly full with modem control on
    assign request_to_send_line_n_o = !q.re || (q.mce && (q.rx_cnt >= `RTS_LEVEL));
    assign serial_clock_pin_o       = q.sck_q;
    assign serial_clock_pin_oe_o    = q.clk_out && !q.clk_ext;

endmodule

`default_nettype wire

// ### include/fifo_uart_consts.svh
`ifndef FIFO_UART_CONSTS_SVH
`define FIFO_UART_CONSTS_SVH

`define FIFO_DEPTH       16
`define OVERSAMPLE_LAST  4'hF
`define MID_BIT_TICK     4'h7

`define MODE_OFS         5'h00
`define CTRL_OFS         5'h04
`define BAUD_OFS         5'h08
`define TXDATA_OFS       5'h0C
`define RXDATA_OFS       5'h10
`define COUNT_OFS        5'h14
`define STATUS_OFS       5'h18
`define MASK_OFS         5'h1C

`define MODE_CHAR7_BIT   6
`define MODE_PAR_EN_BIT  5
`define MODE_PAR_ODD_BIT 4
`define MODE_STOP2_BIT   3

`define CTRL_TE_BIT      5
`define CTRL_RE_BIT      4
`define CTRL_MCE_BIT     3
`define CTRL_CLKOUT_BIT  2
`define CTRL_CLKSRC_BIT  1

`define ST_RX_READY      0
`define ST_RX_FULL       1
`define ST_PARITY        2
`define ST_FRAMING       3
`define ST_BREAK         4
`define ST_OVERRUN       5
`define ST_TX_EMPTY      6
`define STATUS_W         7

`define BAUD_DIV_RST     16'h000C
`define RTS_LEVEL        5'h0F

`endif

// ### include/fifo_uart_pkg.sv
package fifo_uart_pkg;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;

    typedef struct packed {
        logic char7;
        logic par_en;
        logic par_odd;
        logic stop2;
    } frame_cfg_type;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

endpackage

// ### testbench/fifo_serial_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_uart_consts.svh"

module fifo_serial_port_properties
    import fifo_uart_pkg::*;
(
    // clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // register port
    input wire reg_req_type req_i,
    input wire logic [15:0] rdata_o,
    input wire logic        irq_o,
    // serial line and modem control
    input wire logic        serial_in_i,
    input wire logic        serial_out_o,
    input wire logic        request_to_send_line_n_o,
    input wire logic        clear_to_send_line_n_i,
    // serial clock pin
    input wire logic        serial_clock_pin_i,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe_o
);
    logic [15:0] ctrl_q, baud_q, mask_q;
    logic [7:0]  run_q;
    logic        last_q;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // shadows of what software wrote, so outputs can be tied to their cause
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_q <= 16'h0000;
            baud_q <= `BAUD_DIV_RST;
            mask_q <= 16'h0000;
            run_q  <= 8'h00;
            last_q <= 1'b1;
        end else begin
            if (ce_i && req_i.wr && req_i.addr == `CTRL_OFS) ctrl_q <= req_i.wdata;
            if (ce_i && req_i.wr && req_i.addr == `BAUD_OFS) baud_q <= req_i.wdata;
            if (ce_i && req_i.wr && req_i.addr == `MASK_OFS) mask_q <= req_i.wdata;
            last_q <= serial_out_o;
            // saturating run length of the current line level
            if (serial_out_o != last_q) run_q <= 8'h00;
            else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
        end
    end

    reset_state_a: assert property ($fell(rst_i) |-> serial_out_o && !irq_o)
        else $error("line not idle after reset");
    read_zero_a: assert property (!req_i.rd |=> rdata_o == 16'h0000)
        else $error("read data outside read answer");
    bit_length_a: assert property (serial_out_o && !last_q |-> run_q >= 8'd15)
        else $error("low bit shorter than sixteen ticks");
    start_hold_a: assert property ($fell(serial_out_o) |-> !serial_out_o [*8])
        else $error("start bit released early");
    clock_oe_a: assert property ($stable(ctrl_q) |->
        serial_clock_pin_oe_o == (ctrl_q[2] && !ctrl_q[1]))
        else $error("clock pin enable wrong");
    rts_level_a: assert property ($stable(ctrl_q) && !ctrl_q[3] |->
        request_to_send_line_n_o == !ctrl_q[4])
        else $error("request to send level wrong");
    clock_out_a: assert property (serial_clock_pin_oe_o && baud_q == 16'h000C |->
        ##[1:14] $rose(serial_clock_pin_o))
        else $error("clock out not toggling");
    irq_masked_a: assert property ($stable(mask_q) && mask_q == 16'h0000 |-> !irq_o)
        else $error("interrupt while all masked");
    cts_hold_a: assert property (ctrl_q[3] && baud_q == 16'h0000 && run_q > 8'd200
        && serial_out_o && clear_to_send_line_n_i && $past(clear_to_send_line_n_i)
        |=> serial_out_o)
        else $error("frame started while clear to send off");

    cover property ($fell(serial_out_o));
    cover property (irq_o);
    cover property (serial_clock_pin_oe_o && $rose(serial_clock_pin_o));
endmodule

bind fifo_serial_port fifo_serial_port_properties i_props (
    .clock_i, .rst_i, .ce_i, .req_i, .rdata_o, .irq_o, .serial_in_i, .serial_out_o,
    .request_to_send_line_n_o, .clear_to_send_line_n_i, .serial_clock_pin_i,
    .serial_clock_pin_o, .serial_clock_pin_oe_o
);

`default_nettype wire

// ### testbench/serial_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module serial_peer_model
    import fifo_uart_pkg::*;
(
    // line towards the device
    input  wire logic line_i,
    output var logic  line_o,
    // modem control and clock pin
    output var logic  cts_n_o,
    output var logic  ext_clk_o
);
    frame_cfg_type cfg;
    int            bit_ns;
    bit            ext_run;
    logic [10:0]   got_q[$];

    initial begin
        line_o = 1'b1;
        cts_n_o = 1'b0;
        ext_clk_o = 1'b0;
        cfg = '0;
        bit_ns = 640;
    end

    // free running once enabled: stopping it mid-run leaves the port undefined
    always begin
        #80;
        if (ext_run) ext_clk_o = ~ext_clk_o;
    end

    // each frame is timed afresh from its own start edge, sampled mid-bit
    initial forever begin
        logic [10:0] f;
        @(negedge line_i);
        f = 11'h600;
        #(bit_ns / 2);
        if (line_i === 1'b0) begin
            for (int i = 0; i < (cfg.char7 ? 7 : 8); i++) begin
                #(bit_ns);
                f[i] = line_i;
            end
            if (cfg.par_en) begin
                #(bit_ns);
                f[8] = line_i;
            end
            #(bit_ns);
            f[9] = line_i;
            if (cfg.stop2) begin
                #(bit_ns);
                f[10] = line_i;
            end
            got_q.push_back(f);
        end
    end

    task automatic send(input logic [7:0] d, input logic bad_par, input logic s1,
                        input logic s2);
        logic [7:0] m;
        m = cfg.char7 ? {1'b0, d[6:0]} : d;
        #7;
        line_o = 1'b0;
        for (int i = 0; i < (cfg.char7 ? 7 : 8); i++) begin
            #(bit_ns);
            line_o = m[i];
        end
        if (cfg.par_en) begin
            #(bit_ns);
            line_o = ^m ^ cfg.par_odd ^ bad_par;
        end
        #(bit_ns);
        line_o = s1;
        if (cfg.stop2) begin
            #(bit_ns);
            line_o = s2;
        end
        #(bit_ns);
        line_o = 1'b1;
        #(bit_ns);
    endtask
endmodule

`default_nettype wire

// ### testbench/test_fifo_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fifo_uart_consts.svh"
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module test_fifo_serial_port
    import fifo_uart_pkg::*;
;
    logic        clock_i, rst_i, ce_i, irq_o, serial_in_i, serial_out_o;
    logic        request_to_send_line_n_o, clear_to_send_line_n_i;
    logic        serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_o;
    reg_req_type req_i;
    logic [15:0] rdata_o;
    logic [10:0] fr, ex;
    int          mismatches, total_checks;

    fifo_serial_port i_dut (
        .clock_i, .rst_i, .ce_i, .req_i, .rdata_o, .irq_o, .serial_in_i, .serial_out_o,
        .request_to_send_line_n_o, .clear_to_send_line_n_i, .serial_clock_pin_i,
        .serial_clock_pin_o, .serial_clock_pin_oe_o
    );
    serial_peer_model i_peer (
        .line_i    (serial_out_o),
        .line_o    (serial_in_i),
        .cts_n_o   (clear_to_send_line_n_i),
        .ext_clk_o (serial_clock_pin_i)
    );

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        req_i <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock_i);
        req_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        req_i <= '0;
        #1;
        `CHK(rdata_o, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic get_frame(output logic [10:0] f);
        for (int n = 0; n < 20000 && i_peer.got_q.size() == 0; n++) @(posedge clock_i);
        // a frame that never arrives is a mismatch, not a silent empty pop
        if (i_peer.got_q.size() == 0) begin
            mismatches++;
            f = '0;
        end else begin
            f = i_peer.got_q.pop_front();
        end
    endtask

    // what the far end must see: masked data, parity sense, both stops high
    function automatic logic [10:0] exp_frame(input logic [7:0] d);
        logic [7:0] m;
        m = i_peer.cfg.char7 ? {1'b0, d[6:0]} : d;
        return {2'b11, i_peer.cfg.par_en & (^m ^ i_peer.cfg.par_odd), m};
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        finish_test();
    end

    initial begin
        mismatches = 0;
        total_checks = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        req_i = '0;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(`BAUD_OFS, `BAUD_DIV_RST);
        rd(`COUNT_OFS, 16'h0000);
        rd(5'h02, 16'h0000);
        `CHK(request_to_send_line_n_o, 1'b1)
        wr(`CTRL_OFS, 16'h0004);
        tick(40);
        `CHK(serial_clock_pin_oe_o, 1'b1)
        wr(`CTRL_OFS, 16'h0006);
        tick(2);
        `CHK(serial_clock_pin_oe_o, 1'b0)
        wr(`BAUD_OFS, 16'h0000);
        for (int f = 0; f < 8; f++) begin
            i_peer.cfg = '{f[2], f[1], f[0], f[0]};
            wr(`CTRL_OFS, 16'h0000);
            wr(`MODE_OFS, {9'h000, f[2], f[1], f[0], f[0], 3'h0});
            wr(`CTRL_OFS, 16'h0030);
            wr(`TXDATA_OFS, 16'h00C3 + 16'(f));
            get_frame(fr);
            `CHK(fr, exp_frame(8'hC3 + 8'(f)))
            i_peer.send(8'hBC + 8'(f), 1'b0, 1'b1, 1'b1);
            ex = exp_frame(8'hBC + 8'(f));
            rd(`RXDATA_OFS, {8'h00, ex[7:0]});
            rd(`STATUS_OFS, 16'h0041);
            wr(`STATUS_OFS, 16'h007F);
        end
        // bad parity, then a break with its framing error; both bytes still land
        for (int k = 0; k < 2; k++) begin
            i_peer.send(k != 0 ? 8'h00 : 8'h12, k == 0, k == 0, 1'b1);
            rd(`STATUS_OFS, k != 0 ? 16'h0019 : 16'h0005);
            rd(`RXDATA_OFS, k != 0 ? 16'h0000 : 16'h0012);
            wr(`STATUS_OFS, 16'h007F);
        end
        #5 i_peer.line_o = 1'b0;
        #200 i_peer.line_o = 1'b1;
        tick(40);
        rd(`COUNT_OFS, 16'h0000);
        rd(`STATUS_OFS, 16'h0000);
        i_peer.send(8'h55, 1'b0, 1'b1, 1'b1);
        `CHK(irq_o, 1'b0)
        wr(`MASK_OFS, 16'h0001);
        tick(1);
        `CHK(irq_o, 1'b1)
        wr(`STATUS_OFS, 16'h0001);
        tick(1);
        `CHK(irq_o, 1'b0)
        rd(`RXDATA_OFS, 16'h0055);
        wr(`CTRL_OFS, 16'h0038);
        for (int i = 0; i < 17; i++) begin
            i_peer.send(8'(i), 1'b0, 1'b1, 1'b1);
            if (i == 13) `CHK(request_to_send_line_n_o, 1'b0)
            if (i == 14) `CHK(request_to_send_line_n_o, 1'b1)
        end
        rd(`COUNT_OFS, 16'h0010);
        rd(`STATUS_OFS, 16'h0023);
        for (int i = 0; i < 16; i++) rd(`RXDATA_OFS, 16'(i));
        rd(`COUNT_OFS, 16'h0000);
        wr(`STATUS_OFS, 16'h007F);
        #5 i_peer.cts_n_o = 1'b1;
        for (int i = 0; i < 3; i++) wr(`TXDATA_OFS, 16'h0061 + 16'(i));
        rd(`COUNT_OFS, 16'h0300);
        tick(300);
        `CHK(i_peer.got_q.size(), 0)
        i_peer.cts_n_o = 1'b0;
        for (int i = 0; i < 3; i++) begin
            get_frame(fr);
            `CHK(fr, exp_frame(8'h61 + 8'(i)))
        end
        tick(20);
        i_peer.ext_run = 1'b1;
        i_peer.bit_ns = 2560;
        wr(`CTRL_OFS, 16'h0032);
        wr(`TXDATA_OFS, 16'h005A);
        get_frame(fr);
        `CHK(fr, exp_frame(8'h5A))
        i_peer.send(8'h96, 1'b0, 1'b1, 1'b1);
        rd(`RXDATA_OFS, 16'h0016);
        // a write while the clock enable is low must be lost
        @(posedge clock_i);
        ce_i <= 1'b0;
        wr(`MASK_OFS, 16'h007F);
        ce_i <= 1'b1;
        rd(`MASK_OFS, 16'h0001);
        finish_test();
    end
endmodule

`default_nettype wire
